// file: verilog/tmrc_core.sv
// Mode and reset controller of a revenue meter: test mode entry and
// timeout, demand and master resets, lockout and test pulse outputs.
// Assumes pins arrive asynchronously and software strobes on core_clk_i.
`timescale 1ns/10ps
module tmrc_core #(
   parameter int unsigned SEC_CYC = tmrc_pkg::SEC_CYC,
   parameter int unsigned BTN_N   = tmrc_pkg::BTN_N,
   parameter int unsigned TW      = tmrc_pkg::TIMER_W
) (
   input  wire logic             core_clk_i,      // Core clock, 40 MHz.
   input  wire logic             sys_rst_i,       // Synchronous reset, high.
   input  wire logic             hw_lock_i,       // Hardware lock pin, high.
   input  wire logic             test_btn_i,      // Covered test button pin.
   input  wire logic             mreset_btn_i,    // Recessed master reset pin.
   input  wire logic             dreset_sw_i,     // Demand reset switch pin.
   input  wire logic [BTN_N-1:0] panel_btn_i,     // Front panel button pins.
   input  wire logic             sw_test_on_i,    // Software test entry pulse.
   input  wire logic             sw_test_off_i,   // Software test exit pulse.
   input  wire logic             sw_mreset_i,     // Software master reset.
   input  wire logic             sw_dreset_i,     // Software demand reset.
   input  wire logic             cfg_wr_i,        // Config write strobe.
   input  wire logic [2:0]       cfg_sel_i,       // Config item selector.
   input  wire logic [31:0]      cfg_data_i,      // Config write data.
   input  wire logic             cfg_dflt_i,      // Apply config defaults.
   input  wire logic             energy_q_i,      // Energy quantum pulse.
   output logic [1:0]            mode_o,          // Current mode code.
   output logic                  test_mode_o,     // High in test mode.
   output logic [TW-1:0]         test_remain_o,   // Seconds to timeout.
   output logic [TW-1:0]         lockout_rem_o,   // Lockout seconds left.
   output logic                  reg_acc_en_o,    // Regular accumulate.
   output logic                  test_acc_en_o,   // Test accumulate.
   output logic                  test_clr_o,      // Zero test accumulators.
   output logic                  test_dem_clr_o,  // Zero test demand.
   output logic                  peak_clr_o,      // Clear peak demand.
   output logic                  reg_zero_o,      // Zero regular values.
   output logic                  log_clr_o,       // Clear logs and files.
   output logic                  dreset_ign_o,    // Demand reset ignored.
   output logic                  req_refused_o,   // Software request refused.
   output logic                  cfg_ack_o,       // Config write taken.
   output logic                  cfg_nak_o,       // Config write refused.
   output logic                  comm_wr_o,       // Pass-on config write.
   output logic                  scale_en_o,      // Ratio scaling on test.
   output logic                  loss_en_o,       // Loss comp on test.
   output logic                  led_pulse_o,     // Energy pulse LED.
   output logic                  ir_pulse_o       // Energy pulse infrared.
);

   // =====================================================================
   // Pin synchronisers
   // =====================================================================
   localparam int unsigned PW = BTN_N + 4;
   logic [PW-1:0] pin_meta_q;
   logic [PW-1:0] pin_sync_q;
   logic [PW-1:0] pin_prev_q;
   logic [PW-1:0] pin_rise;

   // Two synchroniser flops and an edge flop per pin; the first stage feeds no logic.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
         pin_prev_q <= '0;
      end else begin
         pin_meta_q <= {panel_btn_i, dreset_sw_i, mreset_btn_i, test_btn_i, hw_lock_i};
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   // Press detection per pin, bit 0 is the lock level and is not used.
   genvar g;
   generate
      for (g = 0; g < PW; g++) begin : g_edge
         assign pin_rise[g] = pin_sync_q[g] && !pin_prev_q[g];
      end
   endgenerate

   logic             locked;
   logic             test_press;
   logic             mrst_press;
   logic             drst_press;
   logic [BTN_N-1:0] btn_press;
   logic             any_press;

   assign locked     = pin_sync_q[0];
   assign test_press = pin_rise[1];
   assign mrst_press = pin_rise[2];
   assign drst_press = pin_rise[3];
   assign btn_press  = pin_rise[PW-1:4];
   assign any_press  = |pin_rise[PW-1:1];

   // =====================================================================
   // Configuration registers
   // =====================================================================
   logic [TW-1:0] test_to_q;
   logic [TW-1:0] lockout_q;
   logic [15:0]   pulse_div_q;
   logic          scale_q;
   logic          loss_q;
   // Test mode flag, shared by the config gate and the mode state below.
   logic          in_test;
   logic          cfg_ok;
   logic          cfg_take;
   logic          dflt_take;

   // Locked in regular or secondary mode only comm settings pass.
   assign cfg_ok    = !locked || in_test || (cfg_sel_i == tmrc_pkg::SEL_COMM);
   assign cfg_take  = cfg_wr_i && cfg_ok;
   assign dflt_take = cfg_dflt_i && (!locked || in_test);
   assign cfg_ack_o = cfg_take || dflt_take;
   assign cfg_nak_o = (cfg_wr_i && !cfg_ok) || (cfg_dflt_i && !dflt_take);

   // Items held outside this block are handed on once accepted.
   assign comm_wr_o = cfg_take && ((cfg_sel_i == tmrc_pkg::SEL_COMM)
                                || (cfg_sel_i == tmrc_pkg::SEL_OTHER));

   // Timeout, lockout, options and pulse divider; defaults on request.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || dflt_take) begin
         test_to_q   <= TW'(tmrc_pkg::TEST_TO_DEF_S);
         lockout_q   <= TW'(tmrc_pkg::LOCKOUT_DEF_S);
         pulse_div_q <= tmrc_pkg::PULSE_DIV_DEF;
         scale_q     <= 1'b0;
         loss_q      <= 1'b0;
      end else if (cfg_take) begin
         case (cfg_sel_i)
            tmrc_pkg::SEL_TEST_TO: test_to_q   <= TW'(cfg_data_i);
            tmrc_pkg::SEL_LOCKOUT: lockout_q   <= TW'(cfg_data_i);
            tmrc_pkg::SEL_SCALE:   scale_q     <= cfg_data_i[0];
            tmrc_pkg::SEL_LOSS:    loss_q      <= cfg_data_i[0];
            tmrc_pkg::SEL_PULSE:   pulse_div_q <= cfg_data_i[15:0];
            default: begin
            end
         endcase
      end
   end

   assign scale_en_o = scale_q;
   assign loss_en_o  = loss_q;

   // =====================================================================
   // Second tick and timers
   // =====================================================================
   logic tick;

   tmrc_tick_div #(
      .CYC (SEC_CYC)
   ) u_tick (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .tick_o     (tick)
   );

   logic          enter_test;
   logic          to_load;
   logic          to_expire;
   logic [TW-1:0] to_count;

   // Entry and every press in test mode reload the full timeout.
   assign to_load = enter_test || (in_test && any_press);

   tmrc_sec_timer #(
      .W (TW)
   ) u_test_to (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .load_i     (to_load),
      .load_val_i (test_to_q),
      .tick_i     (tick && in_test),
      .count_o    (to_count),
      .expire_o   (to_expire)
   );

   // Remaining time is shown only while test mode runs.
   assign test_remain_o = in_test ? to_count : '0;

   logic          drst_req;
   logic          drst_take;
   logic [TW-1:0] lock_count;

   // A demand reset inside the lockout window is dropped.
   assign drst_req  = drst_press || sw_dreset_i;
   assign drst_take = drst_req && (lock_count == '0);

   tmrc_sec_timer #(
      .W (TW)
   ) u_lockout (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .load_i     (drst_take),
      .load_val_i (lockout_q),
      .tick_i     (tick),
      .count_o    (lock_count),
      .expire_o   ()
   );

   assign lockout_rem_o = lock_count;

   // =====================================================================
   // Mode state
   // =====================================================================
   tmrc_pkg::tmrc_mode_t mode_q;
   tmrc_pkg::tmrc_mode_t mode_d;
   logic                 sw_test_ok;
   logic                 leave_test;
   logic                 sel_toggle;

   // Software entry is refused under the lock; the button always works.
   assign sw_test_ok = sw_test_on_i && !locked;
   assign enter_test = !in_test && (test_press || sw_test_ok);
   assign leave_test = in_test && (to_expire || sw_test_off_i);
   assign sel_toggle = !in_test && btn_press[tmrc_pkg::BTN_SEL];
   assign in_test    = (mode_q == tmrc_pkg::MODE_TEST);

   // Next mode; any exit from test goes to regular mode.
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         tmrc_pkg::MODE_REG: begin
            if (enter_test) begin
               mode_d = tmrc_pkg::MODE_TEST;
            end else if (sel_toggle) begin
               mode_d = tmrc_pkg::MODE_SEC;
            end
         end
         tmrc_pkg::MODE_SEC: begin
            if (enter_test) begin
               mode_d = tmrc_pkg::MODE_TEST;
            end else if (sel_toggle) begin
               mode_d = tmrc_pkg::MODE_REG;
            end
         end
         tmrc_pkg::MODE_TEST: begin
            if (leave_test) begin
               mode_d = tmrc_pkg::MODE_REG;
            end
         end
         default: mode_d = tmrc_pkg::MODE_REG;
      endcase
   end

   // System reset always lands in regular mode.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         mode_q <= tmrc_pkg::MODE_REG;
      end else begin
         mode_q <= mode_d;
      end
   end

   assign mode_o      = mode_q;
   assign test_mode_o = in_test;

   // Regular billing pauses in test; values are never touched.
   assign reg_acc_en_o  = !in_test;
   assign test_acc_en_o = in_test;

   // =====================================================================
   // Reset commands
   // =====================================================================
   logic mrst_sw_ok;
   logic mrst_take;
   logic mrst_test;
   logic mrst_reg;
   logic refused_d;

   // Software master reset needs the lock open; the button always works.
   assign mrst_sw_ok = sw_mreset_i && !locked;
   assign mrst_take  = mrst_press || mrst_sw_ok;
   assign mrst_test  = mrst_take && in_test;
   assign mrst_reg   = mrst_take && !in_test;
   assign refused_d  = (sw_mreset_i && locked) || (sw_test_on_i && locked);

   // Registered command pulses toward the accumulators and stores.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         test_clr_o     <= 1'b0;
         test_dem_clr_o <= 1'b0;
         peak_clr_o     <= 1'b0;
         reg_zero_o     <= 1'b0;
         log_clr_o      <= 1'b0;
         dreset_ign_o   <= 1'b0;
         req_refused_o  <= 1'b0;
      end else begin
         test_clr_o     <= leave_test || mrst_test;
         test_dem_clr_o <= drst_take && in_test;
         peak_clr_o     <= (drst_take && !in_test) || mrst_reg;
         reg_zero_o     <= mrst_reg;
         log_clr_o      <= mrst_reg;
         dreset_ign_o   <= drst_req && !drst_take;
         req_refused_o  <= refused_d;
      end
   end

   // =====================================================================
   // Test energy pulsing
   // =====================================================================
   logic [15:0] pls_cnt_q;
   logic        pls_hit;
   logic        pls_out_q;

   // One output pulse per pulse_div_q energy quanta, test mode only.
   assign pls_hit = in_test && energy_q_i && (pls_cnt_q + 16'h0001 >= pulse_div_q);

   // The divider is cleared outside test so each session starts aligned.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || !in_test) begin
         pls_cnt_q <= 16'h0000;
         pls_out_q <= 1'b0;
      end else begin
         pls_out_q <= pls_hit;
         if (pls_hit) begin
            pls_cnt_q <= 16'h0000;
         end else if (energy_q_i) begin
            pls_cnt_q <= pls_cnt_q + 16'h0001;
         end
      end
   end

   assign led_pulse_o = pls_out_q;
   assign ir_pulse_o  = pls_out_q;

endmodule // tmrc_core

// file: verilog/tmrc_pkg.sv
// Constants, mode type and configuration selectors for the test mode and
// reset controller. Assumes a 40 MHz core clock and one synchronous reset.
//
// Overview of operation
// - Hardware lock blocks software test entry; only the covered test button enters.
// - Locked in regular mode, only basic communication settings may change.
// - Without button presses, test mode ends when timeout expires; default 1800 s.
// - Any front panel press in test mode reloads the full timeout.
// - Remaining timeout is presented continuously while in test mode.
// - Timeout expiry always returns to regular mode, never secondary display.
// - Timeout is whole seconds; when locked it changes only in test mode.
// - Test accumulators are separate and accumulate only in test mode.
// - Demand reset in test mode zeroes test demand only, peaks untouched.
// - Demand reset in regular mode clears stored peak demand values.
// - Pulse LED and infrared outputs emit energy pulses in test mode.
// - Unlocked: software master reset any mode; locked: only recessed button.
// - Master reset outside test zeroes energy, demand, peaks, losses, min/max, counters.
// - Master reset outside test also clears logs, recorders and stored files.
// - Master reset in test mode zeroes only test energy and demand.
// - Demand resets inside the lockout interval after an accepted one are ignored.
// - Lockout interval defaults to 25 days when defaults are applied.
// - Transformer ratio scaling of test values is selectable, off by default.
// - Loss compensation on test values is a selectable option.
// - Leaving test mode by any means clears every test accumulator.
// - Leaving test mode always lands in regular mode.
// - Regular accumulators pause in test mode and resume unchanged afterwards.
package tmrc_pkg;

   // =====================================================================
   // Timing
   // =====================================================================
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned TICK_PERIOD_NS = 1_000_000_000;
   localparam int unsigned SEC_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned TIMER_W = 32;
   localparam logic [31:0] TEST_TO_DEF_S = 32'h0000_0708;
   localparam int unsigned LOCKOUT_DEF_DAYS = 25;
   localparam int unsigned SEC_PER_DAY = 86400;
   localparam logic [31:0] LOCKOUT_DEF_S = 32'(LOCKOUT_DEF_DAYS * SEC_PER_DAY);
   localparam logic [15:0] PULSE_DIV_DEF = 16'h0001;

   // =====================================================================
   // Front panel button positions
   // =====================================================================
   localparam int unsigned BTN_N = 3;
   localparam int unsigned BTN_UP = 0;
   localparam int unsigned BTN_DOWN = 1;
   localparam int unsigned BTN_SEL = 2;

   // =====================================================================
   // Configuration selectors
   // =====================================================================
   localparam logic [2:0] SEL_COMM = 3'h0;
   localparam logic [2:0] SEL_TEST_TO = 3'h1;
   localparam logic [2:0] SEL_LOCKOUT = 3'h2;
   localparam logic [2:0] SEL_SCALE = 3'h3;
   localparam logic [2:0] SEL_LOSS = 3'h4;
   localparam logic [2:0] SEL_PULSE = 3'h5;
   localparam logic [2:0] SEL_OTHER = 3'h6;

   typedef enum logic [1:0] {
      MODE_REG,
      MODE_SEC,
      MODE_TEST
   } tmrc_mode_t;

endpackage

// file: verilog/tmrc_tick_div.sv
// One-second enable pulse from the core clock.
// Assumes a free-running core clock; the pulse lasts one clock cycle.
`timescale 1ns/10ps
module tmrc_tick_div #(
   parameter int unsigned CYC = 40_000_000
) (
   input  wire logic core_clk_i,   // Core clock.
   input  wire logic sys_rst_i,    // Synchronous reset, active high.
   output logic      tick_o        // One-cycle pulse each second.
);

   // =====================================================================
   // Divider
   // =====================================================================
   logic [31:0] cnt_q;
   logic        wrap;

   assign wrap = (cnt_q == 32'(CYC - 1));

   // Counter wraps once per second and flags the wrap.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cnt_q  <= 32'h0000_0000;
         tick_o <= 1'b0;
      end else begin
         cnt_q  <= wrap ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
         tick_o <= wrap;
      end
   end

endmodule // tmrc_tick_div

// file: verilog/tmrc_sec_timer.sv
// Down counter in whole seconds with a load, used for the test timeout
// and the demand reset lockout. Assumes a one-cycle tick enable.
`timescale 1ns/10ps
module tmrc_sec_timer #(
   parameter int unsigned W = 32
) (
   input  wire logic         core_clk_i,  // Core clock.
   input  wire logic         sys_rst_i,   // Synchronous reset, active high.
   input  wire logic         load_i,      // Reload with load_val_i.
   input  wire logic [W-1:0] load_val_i,  // Reload value in seconds.
   input  wire logic         tick_i,      // One-second enable.
   output logic [W-1:0]      count_o,     // Seconds remaining.
   output logic              expire_o     // Pulse when count reaches zero.
);

   // =====================================================================
   // Counter
   // =====================================================================
   logic last;

   assign last = tick_i && (count_o == W'(1));

   // Load wins over a tick so a press on the tick edge gives the full time.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         count_o  <= '0;
         expire_o <= 1'b0;
      end else begin
         expire_o <= !load_i && last;
         if (load_i) begin
            count_o <= load_val_i;
         end else if (tick_i && (count_o != '0)) begin
            count_o <= count_o - W'(1);
         end
      end
   end

endmodule // tmrc_sec_timer

// file: testbench/tmrc_core_checker.sv
// Concurrent checks on the ports of the test mode and reset controller.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/10ps
module tmrc_core_checker (
   input wire logic        core_clk_i, sys_rst_i, hw_lock_i,   // Clock, reset, lock.
   input wire logic        sw_test_on_i, sw_mreset_i,          // Software requests.
   input wire logic        sw_dreset_i, cfg_wr_i, energy_q_i,  // Strobes.
   input wire logic [2:0]  cfg_sel_i,                          // Config selector.
   input wire logic [1:0]  mode_o,                             // Mode code.
   input wire logic [31:0] lockout_rem_o,                      // Lockout left.
   input wire logic        test_mode_o, reg_acc_en_o, test_acc_en_o,  // Mode levels.
   input wire logic        test_clr_o, test_dem_clr_o, peak_clr_o,   // Clear pulses.
   input wire logic        reg_zero_o, log_clr_o, dreset_ign_o,      // Reset pulses.
   input wire logic        req_refused_o, cfg_ack_o, cfg_nak_o,      // Answers.
   input wire logic        led_pulse_o, ir_pulse_o                   // Energy pulses.
);
   // ======================================================================
   // Properties
   // ======================================================================
   // The lock counts as settled only after it has passed the pin synchroniser.
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_sw_refuse; sw_test_on_i && hw_lock_i && $past(hw_lock_i, 3) |=> req_refused_o; endproperty
   property p_cfg_nak; cfg_wr_i && cfg_sel_i != 3'h0 && hw_lock_i && $past(hw_lock_i, 3)
      && !test_mode_o |-> cfg_nak_o && !cfg_ack_o; endproperty
   property p_mr_refuse; sw_mreset_i && hw_lock_i && $past(hw_lock_i, 3)
      |=> req_refused_o && !reg_zero_o && !test_clr_o; endproperty
   property p_exit_reg; $fell(test_mode_o) |-> mode_o == 2'h0; endproperty
   property p_exit_clr; $fell(test_mode_o) |-> ##[0:1] test_clr_o; endproperty
   property p_acc; test_acc_en_o == test_mode_o && reg_acc_en_o == !test_mode_o; endproperty
   property p_dem_reg; sw_dreset_i && lockout_rem_o == 32'h0 && !test_mode_o
      |=> peak_clr_o && !test_dem_clr_o; endproperty
   property p_dem_test; sw_dreset_i && lockout_rem_o == 32'h0 && test_mode_o
      |=> test_dem_clr_o && !peak_clr_o; endproperty
   property p_dem_lock; sw_dreset_i && lockout_rem_o != 32'h0
      |=> dreset_ign_o && !peak_clr_o && !test_dem_clr_o; endproperty
   property p_mr_test; sw_mreset_i && !hw_lock_i && !$past(hw_lock_i, 3) && test_mode_o
      |=> test_clr_o && !reg_zero_o && !log_clr_o; endproperty
   property p_pulse; led_pulse_o |-> ir_pulse_o && $past(energy_q_i) && $past(test_mode_o);
   endproperty
   a_sw_refuse: assert property (p_sw_refuse) else $error("software test entry taken");
   a_cfg_nak: assert property (p_cfg_nak) else $error("locked config write taken");
   a_mr_refuse: assert property (p_mr_refuse) else $error("locked master reset taken");
   a_exit_reg: assert property (p_exit_reg) else $error("exit not to regular");
   a_exit_clr: assert property (p_exit_clr) else $error("test values kept on exit");
   a_acc: assert property (p_acc) else $error("accumulate enables wrong");
   a_dem_reg: assert property (p_dem_reg) else $error("peak demand not cleared");
   a_dem_test: assert property (p_dem_test) else $error("test demand not cleared");
   a_dem_lock: assert property (p_dem_lock) else $error("demand reset not ignored");
   a_mr_test: assert property (p_mr_test) else $error("test master reset wrong");
   a_pulse: assert property (p_pulse) else $error("stray energy pulse");
   c_test: cover property ($rose(test_mode_o));
   c_ign: cover property (dreset_ign_o);
   c_led: cover property (led_pulse_o);
endmodule // tmrc_core_checker
bind tmrc_core tmrc_core_checker CHKR (.*);

// file: testbench/tmrc_panel_model.sv
// Front panel model: buttons and switches pressed by a user.
// Assumes press() is called just after a core clock edge.
`timescale 1ns/10ps
module tmrc_panel_model (
   input  wire logic  core_clk_i,    // Core clock.
   output logic [5:0] pins_o         // Demand, master, test, select, down, up.
);
   // ======================================================================
   // Presses
   // ======================================================================
   // A press outlasts the pin synchroniser; open contacts read low.
   initial pins_o = 6'h00;
   task automatic press(input int k);
      pins_o[k] = 1'b1;
      repeat (5) @(posedge core_clk_i);
      #1 pins_o[k] = 1'b0;
   endtask
endmodule // tmrc_panel_model

// file: testbench/test_mode_and_reset_control_bench.sv
// Self-checking bench for the test mode and reset controller.
// Assumes a 40 MHz clock and a shortened one-second tick.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_mode_and_reset_control_bench;
   localparam int unsigned SC = 20;
   logic core_clk_i = 1'b0, sys_rst_i = 1'b1, hw_lock_i = 1'b0, cfg_wr_i = 1'b0;
   logic cfg_dflt_i = 1'b0, energy_q_i = 1'b0, test_btn_i, mreset_btn_i, dreset_sw_i;
   logic [2:0] cfg_sel_i = 3'h0, panel_btn_i;
   logic [31:0] cfg_data_i = 32'h0, test_remain_o, lockout_rem_o;
   logic [1:0] mode_o;
   logic [3:0] swv = 4'h0;
   logic test_mode_o, reg_acc_en_o, test_acc_en_o, test_clr_o, test_dem_clr_o, peak_clr_o;
   logic reg_zero_o, log_clr_o, dreset_ign_o, req_refused_o, cfg_ack_o, cfg_nak_o;
   logic comm_wr_o, scale_en_o, loss_en_o, led_pulse_o, ir_pulse_o;
   wire logic sw_test_on_i = swv[0], sw_test_off_i = swv[1];
   wire logic sw_mreset_i = swv[2], sw_dreset_i = swv[3];
   int err_total = 0, checked = 0, n;
   tmrc_core #(.SEC_CYC(SC)) DUT (.*);
   tmrc_panel_model PNL (.core_clk_i, .pins_o({dreset_sw_i, mreset_btn_i, test_btn_i, panel_btn_i}));
   always #12.5 core_clk_i = ~core_clk_i;
   // ======================================================================
   // Drivers
   // ======================================================================
   task cyc(input int k); repeat (k) @(posedge core_clk_i); #1; endtask
   task sw(input int k); swv[k] = 1'b1; cyc(1); swv[k] = 1'b0; endtask
   task cfgw(input logic [2:0] s, input logic [31:0] d, input logic ok);
      cfg_sel_i = s; cfg_data_i = d; cfg_wr_i = 1'b1; #2;
      `CHK({cfg_ack_o, cfg_nak_o}, {ok, !ok})
      `CHK(comm_wr_o, ok && (s == tmrc_pkg::SEL_COMM || s == tmrc_pkg::SEL_OTHER))
      cyc(1);
      cfg_wr_i = 1'b0;
      cyc(1);
   endtask
   // ======================================================================
   // Scenarios
   // ======================================================================
   task t_basic;
      `CHK({mode_o, scale_en_o}, 3'h0)
      sw(0);
      `CHK(test_remain_o, tmrc_pkg::TEST_TO_DEF_S)
      sw(1);
      `CHK({test_clr_o, reg_acc_en_o}, 2'h3)
      PNL.press(2); cyc(2);
      `CHK(mode_o, 2'h1)
      sw(0); sw(1);
      `CHK(mode_o, 2'h0)
   endtask
   task t_lock;
      hw_lock_i = 1'b1; cyc(4); sw(0);
      `CHK({req_refused_o, mode_o}, 3'h4)
      sw(2);
      `CHK({req_refused_o, reg_zero_o}, 2'h2)
      cfgw(tmrc_pkg::SEL_TEST_TO, 32'h3, 1'b0);
      cfgw(tmrc_pkg::SEL_COMM, 32'h5, 1'b1);
      PNL.press(3); cyc(2);
      `CHK(mode_o, 2'h2)
      cfgw(tmrc_pkg::SEL_TEST_TO, 32'h3, 1'b1);
      cfgw(tmrc_pkg::SEL_SCALE, 32'h1, 1'b1);
      cfgw(tmrc_pkg::SEL_LOSS, 32'h1, 1'b1);
      `CHK({scale_en_o, loss_en_o}, 2'h3)
      PNL.press(0); cyc(2);
      `CHK(test_remain_o >= 32'h2 && test_remain_o <= 32'h3, 1'b1)
      n = 0;
      while (test_mode_o !== 1'b0 && n < 200) begin n++; cyc(1); end
      `CHK(n >= SC && n <= 3 * SC + 3, 1'b1)
      `CHK({mode_o, test_remain_o}, 34'h0)
      hw_lock_i = 1'b0; cyc(4);
   endtask
   task t_dem;
      cfgw(tmrc_pkg::SEL_LOCKOUT, 32'h2, 1'b1);
      sw(3);
      `CHK({peak_clr_o, test_dem_clr_o, lockout_rem_o}, 34'h2_0000_0002)
      cyc(1);
      sw(3);
      `CHK({dreset_ign_o, peak_clr_o}, 2'h2)
      cyc(3 * SC); sw(0); sw(3);
      `CHK({peak_clr_o, test_dem_clr_o}, 2'h1)
      energy_q_i = 1'b1; cyc(1); energy_q_i = 1'b0;
      n = ({led_pulse_o, ir_pulse_o} === 2'h3); cyc(1);
      n += ({led_pulse_o, ir_pulse_o} === 2'h3);
      `CHK(n, 1)
      // A divider of two must let the first quantum pass and pulse on the second.
      cfgw(tmrc_pkg::SEL_PULSE, 32'h2, 1'b1);
      energy_q_i = 1'b1;
      cyc(1);
      n = led_pulse_o;
      cyc(1);
      n += 2 * led_pulse_o;
      energy_q_i = 1'b0;
      `CHK(n, 2)
      sw(2);
      `CHK({test_clr_o, reg_zero_o, log_clr_o}, 3'h4)
      sw(1); sw(2);
      `CHK({reg_zero_o, log_clr_o, peak_clr_o}, 3'h7)
      cfg_dflt_i = 1'b1; cyc(1); cfg_dflt_i = 1'b0; cyc(3 * SC); sw(3);
      `CHK(lockout_rem_o, tmrc_pkg::LOCKOUT_DEF_S)
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // The watchdog allows about twenty times the few hundred cycles the run needs.
   initial begin #125000; err_total++; final_report; end
   initial begin
      cyc(3); sys_rst_i = 1'b0; cyc(1);
      t_basic; t_lock; t_dem; final_report;
   end
endmodule // test_mode_and_reset_control_bench
